// ==== protect_register_programming.sv ====
// Purpose: protect-register clear, store and lock with ready/busy on data-out
// Assumes: write enable comes from same-clock logic; pins via sync_pins
// Notes: protection state is volatile here and restarts at reset defaults
`timescale 1ns/100ps
module protect_register_programming
  import protect_pkg::*;
#(
  parameter int TWP_CYCLES = TWP_DEFAULT  // write cycle length in mclk cycles
)
(
  input  wire logic       mclk,         // 40 MHz clock
  input  wire logic       rst,          // async reset, high
  input  wire logic       csPin,        // chip select pin
  input  wire logic       serialClock,  // serial_clock pin
  input  wire logic       serialDataIn, // serial_data_in pin
  input  wire logic       progEnPin,    // program_enable_pin
  input  wire logic       protSelPin,   // protect select pin
  input  wire logic       writeEnabled, // write-enable state, same clock
  input  wire logic [5:0] memAddr,      // address queried for writability
  output logic            doutPin,      // data-out value
  output logic            doutOeN,      // data-out enable, low drives
  output logic            busy,         // internal operation running
  output logic [5:0]      protAddr,     // protection start address
  output logic            protLocked,   // register permanently locked
  output logic            addrWritable  // memAddr may be programmed
);
  localparam logic [BUSY_W-1:0] TWP_LOAD = BUSY_W'(TWP_CYCLES); // busy reload

  // whole block state
  typedef struct packed {
    phase_e            phase;        // frame phase
    logic [3:0]        bitCnt;       // bits after start
    logic [7:0]        shift;        // opcode and address
    logic              pinsOk;       // both pins high so far
    logic              unlock;       // unlock pending
    logic              cleared;      // register emptied by clear
    logic              locked;       // permanent lock
    logic [5:0]        protAddr;     // protection start address
    op_e               pendOp;       // op applied at end of cycle
    logic [BUSY_W-1:0] busyCnt;      // write cycle countdown
    logic              statusShow;   // status indication armed
    logic              doutPin;      // data-out flop
    logic              doutOeN;      // enable flop
    logic              busy;         // busy flop
    logic              addrWritable; // writability flop
  } state_s;

  state_s st_r;   // state
  state_s st_nxt; // next state
  pins_s  lvl;    // synced levels
  pins_s  rise;   // rising pulses
  pins_s  fall;   // falling pulses

  // bring pins into the mclk domain
  sync_pins u_sync
  (
    .mclk   (mclk),
    .rst    (rst),
    .pinsIn ('{cs: csPin, sk: serialClock, di: serialDataIn,
               pe: progEnPin, psel: protSelPin}),
    .lvl    (lvl),
    .rise   (rise),
    .fall   (fall)
  );

  logic       busyNow;   // countdown running
  logic       csFall;    // select falling edge
  logic       frameEnd;  // select fall closing a frame
  logic       skRise;    // usable clock edge
  logic       full;      // exactly a whole command
  logic [1:0] opc;       // received opcode
  logic [5:0] adr;       // received address
  logic       isUnlock;  // frame is unlock
  logic       pinsGood;  // pins held high all frame
  op_e        wantOp;    // protect op requested
  logic       accept;    // protect op accepted

  assign busyNow  = st_r.busyCnt != '0;
  assign csFall   = fall.cs; // select fall from the synchroniser history
  // select edges while busy never reach the decoder
  assign frameEnd = csFall && st_r.phase == PH_SHIFT && !busyNow;
  assign skRise   = rise.sk && lvl.cs && !busyNow;
  assign full     = st_r.bitCnt == CMD_BITS;
  assign opc      = st_r.shift[7:6];
  assign adr      = st_r.shift[5:0];
  assign pinsGood = st_r.pinsOk && lvl.pe && lvl.psel;
  assign isUnlock = full && opc == OPC_MISC && adr[5:4] == TOP_UNLOCK;

  // decode requested protect op
  always_comb
  begin
    wantOp = OP_NONE;
    if (full && opc == OPC_CLEAR)
      wantOp = OP_CLEAR;
    else if (full && opc == OPC_STORE)
      wantOp = OP_STORE;
    else if (full && opc == OPC_MISC && adr[5:4] == TOP_LOCK)
      wantOp = OP_LOCK;
  end

  // all enabling conditions, else ignored except that unlock still drops
  assign accept = frameEnd && wantOp != OP_NONE && st_r.unlock
                  && pinsGood && !st_r.locked
                  && (wantOp != OP_STORE || st_r.cleared);

  // next-state logic
  always_comb
  begin
    st_nxt = st_r;
    // at or above start address refuses, all ones keeps top open
    st_nxt.addrWritable = (memAddr < st_r.protAddr)
                          || (st_r.protAddr == ADDR_ALL_ONES);
    // pins must stay high through the frame
    if (st_r.phase == PH_SHIFT)
      st_nxt.pinsOk = st_r.pinsOk & lvl.pe & lvl.psel;
    // select low resets the command front end
    if (!lvl.cs)
      st_nxt.phase = PH_IDLE;
    if (frameEnd)
    begin
      // every executed frame drops unlock unless it is a valid unlock
      st_nxt.unlock = isUnlock && writeEnabled && pinsGood;
      if (accept)
      begin
        st_nxt.pendOp     = wantOp;
        st_nxt.busyCnt    = TWP_LOAD;
        st_nxt.statusShow = 1'b1;
      end
    end
    else if (skRise)
    begin
      if (st_r.phase == PH_IDLE)
      begin
        // leading zeros ignored; a one is the start bit
        if (lvl.di)
        begin
          st_nxt.phase      = PH_SHIFT;
          st_nxt.bitCnt     = '0;
          st_nxt.pinsOk     = lvl.pe & lvl.psel;
          st_nxt.statusShow = 1'b0;
        end
      end
      else
      begin
        // shift msb first, count saturates on overlong frames
        st_nxt.shift = {st_r.shift[6:0], lvl.di};
        if (st_r.bitCnt != CNT_SAT)
          st_nxt.bitCnt = st_r.bitCnt + 4'h1;
      end
    end
    // write cycle countdown, result lands at its end
    if (busyNow)
    begin
      st_nxt.busyCnt = st_r.busyCnt - BUSY_W'(1);
      if (st_r.busyCnt == BUSY_W'(1))
      begin
        case (st_r.pendOp)
          OP_CLEAR:
          begin
            st_nxt.protAddr = ADDR_ALL_ONES;
            st_nxt.cleared  = 1'b1;
          end
          OP_STORE:
          begin
            st_nxt.protAddr = adr;
            st_nxt.cleared  = 1'b0;
          end
          OP_LOCK:
            st_nxt.locked = 1'b1;
          default:
            st_nxt.locked = st_r.locked;
        endcase
        st_nxt.pendOp = OP_NONE;
      end
    end
    // data-out: status only while select high, polled without clock
    st_nxt.doutOeN = !(lvl.cs && st_r.statusShow);
    st_nxt.doutPin = !busyNow;
    st_nxt.busy    = busyNow;
  end

  // register state
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      st_r          <= '0;
      st_r.protAddr <= ADDR_ALL_ONES;
      st_r.cleared  <= CLEARED_RESET;
      st_r.locked   <= LOCK_RESET;
      st_r.doutOeN  <= 1'b1;
      st_r.doutPin  <= 1'b1;
      st_r.pendOp   <= OP_NONE;
      st_r.phase    <= PH_IDLE;
    end
    else
      st_r <= st_nxt;
  end

  assign doutPin      = st_r.doutPin;
  assign doutOeN      = st_r.doutOeN;
  assign busy         = st_r.busy;
  assign protAddr     = st_r.protAddr;
  assign protLocked   = st_r.locked;
  assign addrWritable = st_r.addrWritable;

  // data-out floats one cycle after select is seen low
  a_dout_float: assert property (@(posedge mclk) disable iff (rst)
    !lvl.cs |=> doutOeN)
    else $error("data-out driven while select low");

  // driven value is the inverse of busy
  a_ready_level: assert property (@(posedge mclk) disable iff (rst)
    !doutOeN |-> doutPin == !busy)
    else $error("data-out level disagrees with busy");

  // locked register never changes again
  a_lock_sticky: assert property (@(posedge mclk) disable iff (rst)
    protLocked |=> protLocked && $stable(protAddr))
    else $error("locked register changed");

  // store only after a clear
  a_store_cleared: assert property (@(posedge mclk) disable iff (rst)
    accept && wantOp == OP_STORE |-> st_r.cleared)
    else $error("store accepted without prior clear");

  // accepted op was preceded by unlock, then busy follows
  a_unlock_first: assert property (@(posedge mclk) disable iff (rst)
    accept |-> st_r.unlock ##1 (busyNow && !st_r.unlock) ##1 busy)
    else $error("protect op without unlock or no busy");

  // no command taken while busy
  a_busy_blocks: assert property (@(posedge mclk) disable iff (rst)
    busyNow |-> !accept && !skRise)
    else $error("command taken while busy");

  // clear ends with all ones
  a_clear_ones: assert property (@(posedge mclk) disable iff (rst)
    st_r.busyCnt == BUSY_W'(1) && st_r.pendOp == OP_CLEAR
    |=> protAddr == ADDR_ALL_ONES && st_r.cleared)
    else $error("clear did not load all ones");

  // protected address reads back not writable
  a_refuse_prot: assert property (@(posedge mclk) disable iff (rst)
    memAddr >= protAddr && protAddr != ADDR_ALL_ONES |=> !addrWritable)
    else $error("protected address reported writable");

  // start bit disarms status indication
  a_start_clears: assert property (@(posedge mclk) disable iff (rst)
    skRise && st_r.phase == PH_IDLE && lvl.di && !frameEnd |=> !st_r.statusShow)
    else $error("start bit left status armed");

  // a non-unlock frame cancels unlock
  a_unlock_drop: assert property (@(posedge mclk) disable iff (rst)
    frameEnd && !isUnlock |=> !st_r.unlock)
    else $error("unlock survived another instruction");

  // valid clear launches a timed clear
  a_clear_launch: assert property (@(posedge mclk) disable iff (rst)
    frameEnd && wantOp == OP_CLEAR && st_r.unlock && pinsGood && !st_r.locked
    |=> busyNow && st_r.pendOp == OP_CLEAR && st_r.busyCnt == TWP_LOAD)
    else $error("valid clear did not start a write cycle");

  // valid store or lock launches programming
  a_prog_launch: assert property (@(posedge mclk) disable iff (rst)
    frameEnd && st_r.unlock && pinsGood && !st_r.locked
    && (wantOp == OP_LOCK || (wantOp == OP_STORE && st_r.cleared))
    |=> busyNow && st_r.pendOp == $past(wantOp))
    else $error("valid store or lock did not start programming");

  // lock only right after unlock
  a_lock_unlock: assert property (@(posedge mclk) disable iff (rst)
    accept && wantOp == OP_LOCK |-> st_r.unlock)
    else $error("lock accepted without unlock");

  // stored address lands at end of cycle
  a_store_addr: assert property (@(posedge mclk) disable iff (rst)
    st_r.busyCnt == BUSY_W'(1) && st_r.pendOp == OP_STORE
    |=> protAddr == $past(adr) && !st_r.cleared)
    else $error("store did not land its address");

  // unlock set only with write enable and both pins
  a_unlock_set: assert property (@(posedge mclk) disable iff (rst)
    frameEnd && isUnlock |=> st_r.unlock == ($past(writeEnabled) && $past(pinsGood)))
    else $error("unlock state disagrees with its conditions");

  // refused protect op starts no cycle and leaves address and lock unchanged
  a_refused_idle: assert property (@(posedge mclk) disable iff (rst)
    frameEnd && wantOp != OP_NONE && !accept
    |=> !busyNow && $stable(protAddr) && $stable(protLocked))
    else $error("refused protect op had an effect");

  // countdown runs on whatever select does
  a_cycle_runs: assert property (@(posedge mclk) disable iff (rst)
    busyNow |=> st_r.busyCnt == $past(st_r.busyCnt) - BUSY_W'(1))
    else $error("write cycle disturbed");

  // busy flag follows a running cycle
  a_busy_flag: assert property (@(posedge mclk) disable iff (rst)
    busyNow |=> busy)
    else $error("busy not reported during write cycle");

  // select low returns the front end to idle
  a_cs_resets: assert property (@(posedge mclk) disable iff (rst)
    !lvl.cs |=> st_r.phase == PH_IDLE)
    else $error("frame survived select low");

  // status shows while select high, no clock needed
  a_poll_shows: assert property (@(posedge mclk) disable iff (rst)
    lvl.cs && st_r.statusShow |=> !doutOeN)
    else $error("status not shown with select high");

  // all ones keeps every address writable
  a_top_open: assert property (@(posedge mclk) disable iff (rst)
    protAddr == ADDR_ALL_ONES |=> addrWritable)
    else $error("top address refused after clear");
endmodule

// ==== protect_pkg.sv ====
// Purpose: shared constants and types for the protect-register programming block
// Assumes: 40 MHz mclk; serial pins sampled by mclk through two flip-flops
// Notes: write cycle time is a plain default, shortened in simulation via a parameter
// Notes on behaviour
// - select fall after clear starts timed clear
// - store saves address; at and above refuse programming
// - store accepted only after a clear
// - store needs unlock as the previous instruction
// - select fall after store/lock starts timed programming
// - lock makes the register permanently unchangeable
// - lock needs unlock as the previous instruction
// - busy while internal operation runs, no commands
// - select high while busy: data-out low/high
// - data-out floats whenever select is low
// - select toggling never disturbs running programming
// - start bit after ready floats data-out again
// - that start bit begins command; select low resets
// - clear loads all ones; top address writable
// - unlock needs write-enable and both pins high
// - register holds six-bit protection start address
// - status polled by select alone, no clock
package protect_pkg;
  // timing
  localparam int WRITE_TIME_US = 10;                    // write cycle time, microseconds
  localparam int CLK_MHZ       = 40;                    // mclk rate
  localparam int TWP_DEFAULT   = WRITE_TIME_US * CLK_MHZ; // cycles of a write cycle
  localparam int BUSY_W        = 20;                    // busy counter width
  localparam int SYNC_W        = 5;                     // synchronised pins
  // command framing
  localparam logic [3:0] CMD_BITS  = 4'h8;              // opcode plus address after start
  localparam logic [3:0] CNT_SAT   = 4'h9;              // overlong frame marker
  localparam logic [1:0] OPC_MISC  = 2'h0;              // unlock / lock group
  localparam logic [1:0] OPC_STORE = 2'h1;              // protect store opcode
  localparam logic [1:0] OPC_CLEAR = 2'h3;              // protect clear opcode
  localparam logic [1:0] TOP_UNLOCK = 2'h3;             // address top bits of unlock
  localparam logic [1:0] TOP_LOCK   = 2'h0;             // address top bits of lock
  localparam logic [5:0] ADDR_ALL_ONES = 6'h3F;         // cleared register value
  localparam logic       LOCK_RESET    = 1'h0;          // lock state after reset
  localparam logic       CLEARED_RESET = 1'h1;          // cleared state after reset

  typedef enum logic { PH_IDLE = 1'b0, PH_SHIFT = 1'b1 } phase_e;
  typedef enum logic [1:0]
  {
    OP_NONE  = 2'b00,
    OP_CLEAR = 2'b01,
    OP_STORE = 2'b10,
    OP_LOCK  = 2'b11
  } op_e;

  // serial pins as one carrier
  typedef struct packed {
    logic cs;    // chip select
    logic sk;    // serial_clock
    logic di;    // serial_data_in
    logic pe;    // program_enable_pin
    logic psel;  // protect select
  } pins_s;
endpackage

// ==== sync_pins.sv ====
// Purpose: two-flop synchroniser and edge finder for the serial pins
// Assumes: pins are asynchronous to mclk
// Notes: edges come from the second and third stages only
`timescale 1ns/100ps
module sync_pins
  import protect_pkg::*;
(
  input  wire logic  mclk,    // system clock
  input  wire logic  rst,     // async reset, high
  input  wire pins_s pinsIn,  // raw pins
  output pins_s      lvl,     // synchronised levels
  output pins_s      rise,    // one-cycle rising pulses
  output pins_s      fall     // one-cycle falling pulses
);
  typedef struct packed {
    logic [SYNC_W-1:0] s1;  // first stage, read only by s2
    logic [SYNC_W-1:0] s2;  // second stage
    logic [SYNC_W-1:0] s3;  // history for edges
  } sync_s;

  sync_s st_r;   // state
  sync_s st_nxt; // next state

  // shift pins through the stages
  always_comb
  begin
    st_nxt    = st_r;
    st_nxt.s1 = pinsIn;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
  end

  // register stages
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      st_r <= '0;
    else
      st_r <= st_nxt;
  end

  assign lvl  = st_r.s2;
  assign rise = st_r.s2 & ~st_r.s3;
  assign fall = ~st_r.s2 & st_r.s3;
endmodule

// ==== host_model.sv ====
// Purpose: host side of the serial bus, sends frames and polls status
// Assumes: serial clock period of 8 mclk, idle low outside frames
// Notes: data-in shows the inverted last bit once a frame ends
`timescale 1ns/100ps
module host_model
(
  input  wire logic mclk,         // system clock
  output logic      csPin,        // chip select
  output logic      serialClock,  // serial_clock
  output logic      serialDataIn, // serial_data_in
  output logic      progEnPin,    // program_enable_pin
  output logic      protSelPin    // protect select
);
  // idle levels from time zero
  initial
  begin
    csPin = 1'b0;
    serialClock = 1'b0;
    serialDataIn = 1'b0;
    progEnPin = 1'b0;
    protSelPin = 1'b0;
  end

  // step to just after an mclk edge
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #2;
  endtask

  // one bit, data set up half a period before the rise
  task automatic sendBit(input logic b);
    serialDataIn = b;
    tick(4);
    serialClock = 1'b1;
    tick(4);
    serialClock = 1'b0;
  endtask

  // start bit then n body bits msb first; keepCs leaves select high
  task automatic frame(input logic [7:0] body, input int n, input logic [1:0] pins,
                       input logic keepCs);
    progEnPin = pins[1];
    protSelPin = pins[0];
    csPin = 1'b1;
    tick(4);
    sendBit(1'b1);
    for (int i = 0; i < n; i++)
      sendBit(body[7 - i]);
    csPin = keepCs;                // select drops before the next rise
    serialDataIn = ~serialDataIn;  // no stale level once released
    tick(4);
  endtask

  // select alone, no clock, for status polling
  task automatic setCs(input logic v);
    csPin = v;
    tick(4);
  endtask
endmodule

// ==== protect_register_programming_test.sv ====
// Purpose: self-checking bench for protect clear, store and lock
// Assumes: shortened write cycle, host model on the serial pins
// Notes: query port checked against a bench copy of the protection address
`timescale 1ns/100ps
module protect_register_programming_test;
  localparam int TWP = 40;            // shortened write cycle
  localparam logic [7:0] UNL = 8'h30; // unlock body
  localparam logic [7:0] LCK = 8'h00; // lock body
  logic       mclk;                   // system clock
  logic       rst;                    // reset
  logic       csPin;                  // chip select
  logic       serialClock;            // serial_clock
  logic       serialDataIn;           // serial_data_in
  logic       progEnPin;              // program_enable_pin
  logic       protSelPin;             // protect select
  logic       writeEnabled;           // write-enable state
  logic [5:0] memAddr;                // queried address
  logic [5:0] protAddr;               // protection start
  logic [5:0] expProt;                // bench copy of protection start
  logic [5:0] a;                      // random store address
  logic [2:0] rnd;                    // random enables: write enable, pe, psel
  logic       doutPin;                // data-out value
  logic       doutOeN;                // data-out enable, low drives
  logic       busy;                   // operation running
  logic       protLocked;             // permanent lock
  logic       addrWritable;           // query answer
  int         errors;                 // mismatches
  int         samplesChecked;         // comparisons

  protect_register_programming #(.TWP_CYCLES(TWP)) protect_register_programming_i (
    .mclk(mclk), .rst(rst), .csPin(csPin), .serialClock(serialClock),
    .serialDataIn(serialDataIn), .progEnPin(progEnPin), .protSelPin(protSelPin),
    .writeEnabled(writeEnabled), .memAddr(memAddr), .doutPin(doutPin),
    .doutOeN(doutOeN), .busy(busy), .protAddr(protAddr), .protLocked(protLocked),
    .addrWritable(addrWritable));
  host_model host_model_i (
    .mclk(mclk), .csPin(csPin), .serialClock(serialClock),
    .serialDataIn(serialDataIn), .progEnPin(progEnPin), .protSelPin(protSelPin));

  // free-running clock
  initial
    mclk = 1'b0;
  always
    #12.5 mclk = ~mclk;

  // random query addresses
  always @(posedge mclk)
    #2 memAddr = 6'($urandom);

  // expected writability of an address
  function automatic logic wrOk(input logic [5:0] m, input logic [5:0] p);
    return (m < p) || (p == 6'h3F);
  endfunction

  // single-bit compare
  task automatic chkBit(input string name, input logic e, input logic g);
    samplesChecked++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %b seen %b", name, e, g);
    end
  endtask

  // address compare
  task automatic chkAddr(input string name, input logic [5:0] e, input logic [5:0] g);
    samplesChecked++;
    if (g !== e)
    begin
      errors++;
      $display("ERROR %s expected %h seen %h", name, e, g);
    end
  endtask

  // one frame, then busy must match expBusy
  task automatic doCmd(input logic [7:0] body, input int n, input logic pins,
                       input logic expBusy);
    host_model_i.frame(body, n, {pins, pins}, 1'b0);
    host_model_i.tick(10);
    chkBit("busy", expBusy, busy);
    chkBit("doutOeN", 1'b1, doutOeN); // floats with select low
  endtask

  // bounded wait for the end of a write cycle, length checked
  task automatic waitReady(input int done = 0);
    int k;
    k = 0;
    while (busy !== 1'b0 && k < TWP + 20) // no new command before ready
    begin
      host_model_i.tick(1);
      k++;
    end
    chkBit("busyLen", 1'b1, (k + done >= TWP - 12) && (k + done <= TWP));
  endtask

  // query port sweep against the bench copy
  task automatic qcheck(input int n);
    logic [5:0] m;
    repeat (n)
    begin
      @(posedge mclk);
      #3 m = memAddr;
      @(posedge mclk);
      #1 chkBit("addrWritable", wrOk(m, expProt), addrWritable);
    end
  endtask

  // verdict and end of run
  task automatic summarize();
    if (errors == 0 && samplesChecked > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  // watchdog
  initial
  begin
    #1_000_000;
    errors++;
    summarize();
  end

  // main sequence
  initial
  begin
    void'($urandom(9));
    rst = 1'b1;
    writeEnabled = 1'b0;
    memAddr = 6'h00;
    errors = 0;
    samplesChecked = 0;
    repeat (10) @(posedge mclk);
    #2 rst = 1'b0;
    host_model_i.tick(4);
    expProt = 6'h3F;
    chkAddr("protAddr", expProt, protAddr);
    chkBit("protLocked", 1'b0, protLocked);
    doCmd(8'h40 | 8'($urandom % 63), 8, 1'b1, 1'b0); // no unlock first
    doCmd(UNL, 8, 1'b1, 1'b0);
    doCmd(8'hC0, 8, 1'b1, 1'b0);    // unlock without write enable
    writeEnabled = 1'b1;
    doCmd(UNL, 8, 1'b1, 1'b0);
    doCmd(8'hC0, 8, 1'b0, 1'b0);    // pins low during clear
    doCmd(UNL, 8, 1'b1, 1'b0);
    doCmd(8'hC5, 7, 1'b1, 1'b0);    // short frame cancels unlock
    doCmd(8'hC0, 8, 1'b1, 1'b0);
    doCmd(LCK, 8, 1'b1, 1'b0);      // lock without unlock
    chkBit("protLocked", 1'b0, protLocked);
    // random enables on an unlock; the clear runs only with all three high
    for (int j = 0; j < 4; j++)
    begin
      rnd = 3'($urandom);
      writeEnabled = rnd[2];
      host_model_i.frame(UNL, 8, rnd[1:0], 1'b0);
      host_model_i.tick(10);
      doCmd(8'hC0, 8, 1'b1, &rnd);
      if (rnd == 3'h7)
        waitReady();
    end
    writeEnabled = 1'b1;
    doCmd(UNL, 8, 1'b1, 1'b0);
    doCmd(8'hC0 | 8'($urandom % 64), 8, 1'b1, 1'b1); // clear starts cycle
    host_model_i.setCs(1'b1);
    chkBit("doutOeN", 1'b0, doutOeN);
    chkBit("doutPin", 1'b0, doutPin); // busy shows low
    host_model_i.setCs(1'b0);
    chkBit("doutOeN", 1'b1, doutOeN);
    host_model_i.setCs(1'b1);
    chkBit("busy", 1'b1, busy);       // toggling leaves cycle running
    waitReady(12);
    host_model_i.tick(2);
    chkBit("doutPin", 1'b1, doutPin); // ready shows high
    chkBit("doutOeN", 1'b0, doutOeN);
    chkAddr("protAddr", expProt, protAddr);
    host_model_i.frame(8'h00, 0, 2'h3, 1'b1);
    chkBit("doutOeN", 1'b1, doutOeN); // start bit floats data-out
    host_model_i.setCs(1'b0);       // select low ends that frame
    // stores at a corner, a random and a top-1 address
    for (int j = 0; j < 3; j++)
    begin
      a = (j == 0) ? 6'h00 : (j == 1) ? 6'($urandom % 62) : 6'h3E;
      doCmd(UNL, 8, 1'b1, 1'b0);
      doCmd(8'h40 | 8'(a), 8, 1'b1, 1'b1);
      waitReady();
      expProt = a;
      chkAddr("protAddr", expProt, protAddr);
      qcheck(20);
      doCmd(UNL, 8, 1'b1, 1'b0);
      doCmd(8'h7F, 8, 1'b1, 1'b0);  // store without fresh clear
      chkAddr("protAddr", expProt, protAddr);
      doCmd(UNL, 8, 1'b1, 1'b0);
      doCmd(8'hFF, 8, 1'b1, 1'b1);
      waitReady();
      expProt = 6'h3F;
      chkAddr("protAddr", expProt, protAddr);
    end
    doCmd(UNL, 8, 1'b1, 1'b0);
    doCmd(8'h40 | 8'h15, 8, 1'b1, 1'b1);
    waitReady();
    expProt = 6'h15;
    doCmd(UNL, 8, 1'b1, 1'b0);
    doCmd(LCK, 8, 1'b1, 1'b1);
    waitReady();
    chkBit("protLocked", 1'b1, protLocked);
    doCmd(UNL, 8, 1'b1, 1'b0);
    doCmd(8'hC0, 8, 1'b1, 1'b0);    // clear after lock
    chkAddr("protAddr", expProt, protAddr);
    qcheck(20);
    summarize();
  end
endmodule
